// ==== logic/msq_pkg.sv ====
// constants and state type for the module power and reset sequencer
package msq_pkg;
   // clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_MS = 1000000;
   // power-control rise to clock request, typical
   localparam int T_CLKREQ_MS = 100;
   // power-control low until the module is fully off
   localparam int T_OFF_HOLD_MS = 900;
   localparam int CLKREQ_CYC = T_CLKREQ_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int OFF_HOLD_CYC = T_OFF_HOLD_MS * NS_PER_MS / CLK_PERIOD_NS;
   // length of the essential shutdown tasks before the reply
   localparam int SDN_TASK_CYC = 64;
   // timer width holds the longest count
   localparam int TMR_W = 27;
   // reset values of the outputs
   localparam logic POWER_EN_RST = 1'b0;
   localparam logic BB_RESET_RST = 1'b1;
   localparam logic CLKREQ_OE_RST = 1'b0;
   localparam logic PCIE_RST_OE_RST = 1'b0;
   localparam logic PIN_LOW = 1'b0;
   // gray code along off, up, on, shutdown, minimum function, down
   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_UP = 3'h1,
      ST_ON = 3'h3,
      ST_SDN = 3'h2,
      ST_MINF = 3'h6,
      ST_DOWN = 3'h7
   } msq_state_t;
endpackage

// ==== logic/msq_timer.sv ====
// down counter that pulses done when a loaded interval has elapsed
`timescale 1ns/10ps
module msq_timer #(
   parameter int W = msq_pkg::TMR_W
) (
   input wire logic clk,          // system clock
   input wire logic rstn,         // async reset, active low
   input wire logic ce,           // clock enable
   input wire logic start,        // load and start counting
   input wire logic [W-1:0] load, // cycles to count, at least one
   output logic busy,             // counting
   output logic done              // one-cycle pulse at the end
);
   import msq_pkg::*;

   logic [W-1:0] cnt_r;
   logic done_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= '0;
      end else if (ce) begin
         if (start) begin
            cnt_r <= load;
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
         end
      end
   end

   // a restart in the last cycle suppresses the pulse
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         done_r <= 1'b0;
      end else if (ce) begin
         done_r <= !start && (cnt_r == W'(1));
      end
   end

   assign busy = (cnt_r != '0);
   assign done = done_r;

   a_timer_done: assert property (@(posedge clk) disable iff (!rstn)
      ce && !start && cnt_r == W'(1) |=> done_r)
      else $error("timer did not finish after its last count");
endmodule

// ==== logic/msq_sequencer.sv ====
// power-on, power-off, warm and hard reset sequencer inside the module
// Behaviour
// - power-control high with supply present starts power-up.
// - power-control low or floating with supply present turns module off.
// - clock request asserted typically 100 ms after power-control rises.
// - reset input released within 390 ms of PCIe reset; module tolerates it.
// - shutdown command answered OK only after shutdown tasks finish.
// - reset input low puts the module into reset immediately.
// - reset discards data, removes drivers, drops network connection.
// - warm reset keeps module power on.
// - hard reset is full power-off then complete turn-on sequence.
// - in USB mode all PCIe reset and clock request steps are skipped.
// - endpoint mode: reset in, clock request out; root-complex inverts.
`timescale 1ns/10ps
module msq_sequencer #(
   parameter int CLKREQ_CYCLES = msq_pkg::CLKREQ_CYC,
   parameter int OFF_HOLD_CYCLES = msq_pkg::OFF_HOLD_CYC,
   parameter int SDN_CYCLES = msq_pkg::SDN_TASK_CYC
) (
   input wire logic clk,          // system clock, 100 MHz
   input wire logic rstn,         // async reset, active low
   input wire logic ce,           // clock enable, freezes all state
   input wire logic vcc_ok,       // supply present
   input wire logic power_ctl,    // full-card power control, high = on
   input wire logic reset_in_n,   // module reset input, active low
   input wire logic usb_mode,     // host link is USB, PCIe steps skipped
   input wire logic rc_mode,      // module acts as PCIe root complex
   input wire logic pcie_rst_in_n, // PCIe reset from host, endpoint mode
   input wire logic pcie_clock_request_n_in, // clock request, rc mode
   input wire logic shutdown_cmd, // pulse: shutdown command received
   output logic power_en,         // internal power rails enabled
   output logic bb_reset,         // baseband held in reset
   output logic data_clear,       // pulse: volatile data discarded
   output logic drivers_up,       // system drivers loaded
   output logic net_up,           // network connection allowed
   output logic pcie_clock_request_n_out, // open-drain level, always low
   output logic pcie_clock_request_n_oe,  // high while requesting clock
   output logic pcie_rst_out_n,   // open-drain level, always low
   output logic pcie_rst_oe,      // high while holding PCIe reset, rc
   output logic pcie_link_en,     // PCIe link may train
   output logic cmd_ok,           // pulse: shutdown command OK
   output logic cmd_error,        // pulse: shutdown command ERROR
   output logic unsafe_off,       // power dropped without handshake
   output msq_pkg::msq_state_t state // current sequencer state
);
   import msq_pkg::*;
   default clocking msq_cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   msq_state_t state_r, state_nxt;
   logic tmr_start;
   logic [TMR_W-1:0] tmr_load;
   logic tmr_done;
   logic on_req;
   logic active_nxt;
   logic cmd_take, cmd_again;
   logic reset_in_q_r;
   logic power_en_r, bb_reset_r, data_clear_r, drivers_up_r, net_up_r;
   logic clkreq_oe_r, pcie_rst_oe_r, pcie_link_en_r;
   logic cmd_ok_r, cmd_error_r, unsafe_off_r;
   logic pin_low_r;

   msq_timer #(
      .W(TMR_W)
   ) u_timer (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .start(tmr_start),
      .load(tmr_load),
      .busy(),
      .done(tmr_done)
   );

   // a floating pin reads low through the pull-down
   assign on_req = vcc_ok && power_ctl;
   assign cmd_take = shutdown_cmd && reset_in_n && on_req &&
                     (state_r == ST_ON);
   assign cmd_again = shutdown_cmd && reset_in_n && on_req &&
                      (state_r == ST_MINF);

   always_comb begin
      state_nxt = state_r;
      tmr_start = 1'b0;
      tmr_load = '0;
      if (!vcc_ok) begin
         state_nxt = ST_OFF;
      end else begin
         case (state_r)
            ST_OFF: begin
               if (power_ctl) begin
                  state_nxt = ST_UP;
                  tmr_start = 1'b1;
                  tmr_load = TMR_W'(CLKREQ_CYCLES);
               end
            end
            ST_UP, ST_ON, ST_SDN, ST_MINF: begin
               if (!power_ctl) begin
                  state_nxt = ST_DOWN;
                  tmr_start = 1'b1;
                  tmr_load = TMR_W'(OFF_HOLD_CYCLES);
               end else if (state_r == ST_UP && tmr_done) begin
                  state_nxt = ST_ON;
               end else if (cmd_take) begin
                  state_nxt = ST_SDN;
                  tmr_start = 1'b1;
                  tmr_load = TMR_W'(SDN_CYCLES);
               end else if (state_r == ST_SDN && tmr_done) begin
                  state_nxt = ST_MINF;
               end
            end
            ST_DOWN: begin
               if (tmr_done) begin
                  state_nxt = ST_OFF;
               end
            end
            default: begin
               state_nxt = ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_OFF;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   assign active_nxt = (state_nxt != ST_OFF) && (state_nxt != ST_DOWN);

   // power stays up through a warm reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         power_en_r <= POWER_EN_RST;
      end else if (ce) begin
         power_en_r <= active_nxt;
      end
   end

   // reset input acts on the next edge whatever the state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bb_reset_r <= BB_RESET_RST;
         reset_in_q_r <= 1'b1;
         data_clear_r <= 1'b0;
      end else if (ce) begin
         bb_reset_r <= !reset_in_n || !active_nxt;
         reset_in_q_r <= reset_in_n;
         data_clear_r <= reset_in_q_r && !reset_in_n && active_nxt;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         drivers_up_r <= 1'b0;
         net_up_r <= 1'b0;
      end else if (ce) begin
         drivers_up_r <= reset_in_n && active_nxt &&
                         (state_nxt != ST_UP);
         net_up_r <= reset_in_n && (state_nxt == ST_ON);
      end
   end

   // clock request only in endpoint mode over PCIe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clkreq_oe_r <= CLKREQ_OE_RST;
         pin_low_r <= PIN_LOW;
      end else if (ce) begin
         clkreq_oe_r <= !usb_mode && !rc_mode && active_nxt &&
                        (state_nxt != ST_UP);
         pin_low_r <= PIN_LOW;
      end
   end

   // root complex: hold the endpoint in reset until it asks for clock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pcie_rst_oe_r <= PCIE_RST_OE_RST;
      end else if (ce) begin
         pcie_rst_oe_r <= !usb_mode && rc_mode &&
                          !((state_nxt == ST_ON || state_nxt == ST_SDN ||
                             state_nxt == ST_MINF) &&
                            !pcie_clock_request_n_in);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pcie_link_en_r <= 1'b0;
      end else if (ce) begin
         pcie_link_en_r <= !usb_mode && reset_in_n && active_nxt &&
                           (state_nxt != ST_UP) &&
                           (rc_mode ? !pcie_clock_request_n_in
                                    : pcie_rst_in_n);
      end
   end

   // answers to the shutdown command
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmd_ok_r <= 1'b0;
         cmd_error_r <= 1'b0;
      end else if (ce) begin
         cmd_ok_r <= (state_r == ST_SDN && tmr_done && on_req) ||
                     cmd_again;
         cmd_error_r <= shutdown_cmd && !cmd_take && !cmd_again;
      end
   end

   // power removed while running without the shutdown handshake
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         unsafe_off_r <= 1'b0;
      end else if (ce) begin
         if ((state_r == ST_ON || state_r == ST_SDN) &&
             state_nxt == ST_DOWN) begin
            unsafe_off_r <= 1'b1;
         end else if (state_nxt == ST_UP) begin
            unsafe_off_r <= 1'b0;
         end
      end
   end

   assign power_en = power_en_r;
   assign bb_reset = bb_reset_r;
   assign data_clear = data_clear_r;
   assign drivers_up = drivers_up_r;
   assign net_up = net_up_r;
   assign pcie_clock_request_n_out = pin_low_r;
   assign pcie_clock_request_n_oe = clkreq_oe_r;
   assign pcie_rst_out_n = pin_low_r;
   assign pcie_rst_oe = pcie_rst_oe_r;
   assign pcie_link_en = pcie_link_en_r;
   assign cmd_ok = cmd_ok_r;
   assign cmd_error = cmd_error_r;
   assign unsafe_off = unsafe_off_r;
   assign state = state_r;

   sequence s_cmd_taken;
      ce && cmd_take;
   endsequence

   sequence s_no_ok;
      !cmd_ok_r [*8];
   endsequence

   a_power_up_start: assert property (
      ce && state_r == ST_OFF && vcc_ok && power_ctl
      |=> power_en_r && state_r == ST_UP)
      else $error("power-up did not start on power-control high");

   a_off_on_low: assert property (
      ce && vcc_ok && !power_ctl && state_r == ST_ON
      |=> state_r == ST_DOWN && !power_en_r)
      else $error("module stayed on with power-control low");

   a_clkreq_after_up: assert property (
      $rose(clkreq_oe_r) |-> $past(state_r) == ST_UP ||
                             $past(state_r) == ST_ON ||
                             $past(state_r) == ST_SDN ||
                             $past(state_r) == ST_MINF)
      else $error("clock request raised before power-up delay");

   a_ok_not_early: assert property (
      s_cmd_taken |=> s_no_ok)
      else $error("shutdown OK before shutdown tasks finished");

   a_ok_from_sdn: assert property (
      $rose(cmd_ok_r) |-> $past(state_r) == ST_SDN ||
                          $past(state_r) == ST_MINF)
      else $error("shutdown OK outside the handshake");

   a_reset_immediate: assert property (
      ce && !reset_in_n |=> bb_reset_r)
      else $error("reset input did not reset the baseband");

   a_reset_drops: assert property (
      ce && !reset_in_n |=> !net_up_r && !drivers_up_r && !pcie_link_en_r)
      else $error("network or drivers kept during reset");

   a_warm_keeps_power: assert property (
      ce && !reset_in_n && on_req && state_r == ST_ON |=> power_en_r)
      else $error("warm reset removed power");

   a_usb_no_pcie: assert property (
      ce && usb_mode |=> !clkreq_oe_r && !pcie_rst_oe_r && !pcie_link_en_r)
      else $error("PCIe sideband active in USB mode");

   a_rc_no_clkreq: assert property (
      ce && rc_mode |=> !clkreq_oe_r)
      else $error("clock request driven in root-complex mode");
endmodule

// ==== bench/msq_host.sv ====
// host platform model driving the module's power, reset and command pins
`timescale 1ns/10ps
module msq_host #(
   parameter int TICK = 25 // host cycles that stand for 100 ms
) (
   input wire logic clk,     // system clock
   output logic power_ctl,   // power control, high = on
   output logic reset_in_n,  // module reset, active low
   output logic pcie_rst_in_n, // PCIe reset, active low
   output logic shutdown_cmd // pulse: shutdown command sent
);
   initial begin
      power_ctl = 1'b0;
      reset_in_n = 1'b1;
      pcie_rst_in_n = 1'b0;
      shutdown_cmd = 1'b0;
   end
   // every power and reset interval is a whole number of ticks
   task automatic wait_ticks(input int n);
      repeat (n * TICK) @(posedge clk);
      #1;
   endtask
   task automatic power_on();
      wait_ticks(1);
      power_ctl = 1'b1;
      wait_ticks(1);
      pcie_rst_in_n = 1'b1;
      wait_ticks(1);
      reset_in_n = 1'b1;
   endtask
   task automatic power_off();
      pcie_rst_in_n = 1'b0;
      wait_ticks(1);
      reset_in_n = 1'b0;
      wait_ticks(1);
      power_ctl = 1'b0;
      wait_ticks(9);
   endtask
   task automatic warm_reset(input int n);
      reset_in_n = 1'b0;
      wait_ticks(n);
      reset_in_n = 1'b1;
   endtask
   task automatic pulse_cmd();
      @(posedge clk);
      #1;
      shutdown_cmd = 1'b1;
      @(posedge clk);
      #1;
      shutdown_cmd = 1'b0;
   endtask
endmodule

// ==== bench/msq_sequencer_tb.sv ====
// self-checking bench for the module power and reset sequencer
`timescale 1ns/10ps
module msq_sequencer_tb;
   import msq_pkg::*;
   localparam int CLKREQ = 20;
   localparam int OFF_HOLD = 30;
   localparam int SDN = 10;
   localparam int LIMIT = 5000;
   logic clk, rstn, ce, vcc_ok, usb_mode, rc_mode, clkreq_in_n;
   logic power_ctl, reset_in_n, pcie_rst_in_n, shutdown_cmd;
   logic power_en, bb_reset, drivers_up, net_up, clkreq_oe;
   logic cmd_ok, cmd_error, unsafe_off;
   logic data_clear, link_en, rst_oe, clkreq_out_n, rst_out_n;
   msq_state_t state;
   logic [31:0] cyc = 32'h0;
   logic [31:0] rnd;
   logic [33:0] exp_q[$];
   int mismatches, num_checks, n;

   msq_host #(.TICK(25)) msq_host_inst (.clk(clk), .power_ctl(power_ctl),
      .reset_in_n(reset_in_n), .pcie_rst_in_n(pcie_rst_in_n),
      .shutdown_cmd(shutdown_cmd));
   msq_sequencer #(.CLKREQ_CYCLES(CLKREQ), .OFF_HOLD_CYCLES(OFF_HOLD),
      .SDN_CYCLES(SDN)) msq_sequencer_inst (.clk(clk), .rstn(rstn),
      .ce(ce), .vcc_ok(vcc_ok), .power_ctl(power_ctl),
      .reset_in_n(reset_in_n), .usb_mode(usb_mode), .rc_mode(rc_mode),
      .pcie_rst_in_n(pcie_rst_in_n), .pcie_clock_request_n_in(clkreq_in_n),
      .shutdown_cmd(shutdown_cmd), .power_en(power_en),
      .bb_reset(bb_reset), .data_clear(data_clear),
      .drivers_up(drivers_up), .net_up(net_up),
      .pcie_clock_request_n_out(clkreq_out_n),
      .pcie_clock_request_n_oe(clkreq_oe), .pcie_rst_out_n(rst_out_n),
      .pcie_rst_oe(rst_oe), .pcie_link_en(link_en), .cmd_ok(cmd_ok),
      .cmd_error(cmd_error), .unsafe_off(unsafe_off), .state(state));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      num_checks++;
      if (got != exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cmd(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_st(input msq_state_t st, output int k);
      k = 0;
      while (state !== st && k < 1000) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask
   // note the reply in order of the cycle it is due
   task automatic cmd(input logic ok, input int dly);
      logic [33:0] note;
      int i;
      msq_host_inst.pulse_cmd();
      note = {cyc + 32'(dly), ok, !ok};
      i = exp_q.size();
      while (i > 0 && exp_q[i-1] > note) i--;
      exp_q.insert(i, note);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 32'h1;
   always @(posedge clk) begin
      if (cyc == LIMIT) begin
         mismatches++;
         summarize();
      end
   end
   always @(posedge clk) begin
      #2;
      if (cmd_ok === 1'b1 || cmd_error === 1'b1) begin
         if (exp_q.size() == 0) exp_q.push_back(34'h0);
         chk_cmd({cyc, cmd_ok, cmd_error}, exp_q.pop_front());
      end
   end

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      vcc_ok = 1'b1;
      usb_mode = 1'b0;
      rc_mode = 1'b0;
      clkreq_in_n = 1'b1;
      rnd = 32'h0000F1FF;
      mismatches = 0;
      num_checks = 0;
      repeat (4) @(posedge clk);
      #1;
      rstn = 1'b1;
      for (int m = 0; m < 3; m++) begin
         usb_mode = (m == 1);
         rc_mode = (m == 2);
         fork
            msq_host_inst.power_on();
            begin
               wait_st(ST_UP, n);
               chk_bit(power_en, 1'b1);
               wait_st(ST_ON, n);
               chk_cnt(n, CLKREQ + 1);
               chk_bit(clkreq_oe, m == 0);
               chk_bit(rst_oe, m == 2);
               chk_bit(clkreq_out_n | rst_out_n, 1'b0);
            end
         join
         // endpoint asks for clock in root-complex runs
         clkreq_in_n = (m != 2);
         @(posedge clk);
         #1;
         chk_bit(link_en, m != 1);
         chk_bit(rst_oe, 1'b0);
         if (m == 0) begin
            rnd = xs(rnd);
            fork
               msq_host_inst.warm_reset(2 + int'(rnd[1:0]));
               begin
                  @(posedge clk);
                  #1;
                  chk_bit(data_clear, 1'b1);
                  repeat (2) @(posedge clk);
                  #1;
                  chk_bit(data_clear, 1'b0);
                  chk_bit(bb_reset, 1'b1);
                  chk_bit(net_up | drivers_up, 1'b0);
                  chk_bit(power_en, 1'b1);
                  cmd(1'b0, 0);
               end
            join
            repeat (int'(rnd[4:2])) @(posedge clk);
            cmd(1'b1, SDN + 1);
            cmd(1'b0, 0);
            repeat (SDN + 2) @(posedge clk);
            cmd(1'b1, 0);
         end
         fork
            msq_host_inst.power_off();
            begin
               wait_st(ST_DOWN, n);
               chk_bit(power_en, 1'b0);
               chk_bit(unsafe_off, m != 0);
               chk_bit(rst_oe, m == 2);
               chk_bit(link_en, 1'b0);
               wait_st(ST_OFF, n);
               chk_cnt(n, OFF_HOLD + 1);
            end
         join
      end
      chk_cnt(exp_q.size(), 0);
      summarize();
   end
endmodule
